//--- verif/pou_timer_model.sv
// timer channels: compare match A pulse source
`timescale 1ns/1ps
module pou_timer_model (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic [3:0] req_in,
	output logic [3:0] cm_a_out
);
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			cm_a_out <= 4'h0;
		else
			cm_a_out <= req_in;
	end
endmodule : pou_timer_model

//--- verif/pou_top_assertions.sv
// checker on the pattern output unit top ports
`timescale 1ns/1ps
module pou_top_assertions (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic hw_standby_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic [3:0] cm_a_in,
	input wire logic [7:0] port_a_out,
	input wire logic [7:0] port_a_oe_out,
	input wire logic [7:0] port_b_out,
	input wire logic [7:0] port_b_oe_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	wire acc = psel_in && penable_in;
	// no trigger, no write, no standby
	wire quiet = !(|cm_a_in) && !(acc && pwrite_in) && !hw_standby_in;
	a_zero_wait: assert property (pready_out == acc)
		else $error("pready not tied to access");
	a_err_in_access: assert property (pslverr_out |-> acc)
		else $error("pslverr outside access");
	a_rdata_upper: assert property (prdata_out[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_hold_port_a: assert property ($past(quiet) |-> $stable(port_a_out))
		else $error("port a changed without cause");
	a_hold_port_b: assert property ($past(quiet) |-> $stable(port_b_out))
		else $error("port b changed without cause");
	a_hold_dir: assert property ($past(quiet) |-> $stable(port_a_oe_out))
		else $error("direction changed without write");
	a_hold_dir_b: assert property ($past(quiet) |-> $stable(port_b_oe_out))
		else $error("port b direction changed without write");
	a_standby_a: assert property (hw_standby_in |=>
		port_a_out == 8'h00 && port_a_oe_out == 8'h00)
		else $error("standby left port a set");
	a_standby_b: assert property (hw_standby_in |=>
		port_b_out == 8'h00 && port_b_oe_out == 8'h00)
		else $error("standby left port b set");
endmodule : pou_top_assertions
bind pou_top pou_top_assertions chk (.*);

//--- verif/pou_top_bench.sv
// self-checking bench of the pattern output unit
`timescale 1ns/1ps
`include "pou_regs.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	err_total++; $display("BAD %0t mismatch got %h want %h", $time, a, b); \
	end end
module pou_top_bench import pou_pkg::*;;
	logic sys_clk_in = '0, rst_n_in = '0, hw_standby_in = '0;
	logic psel_in = '0, penable_in = '0, pwrite_in = '0;
	logic [19:0] paddr_in = '0;
	logic [31:0] pwdata_in = '0, prdata_out, r;
	logic [3:0] pstrb_in = '0, req = '0, cm_a_in;
	logic pready_out, pslverr_out;
	logic [7:0] port_a_out, port_a_oe_out, port_b_out, port_b_oe_out;
	logic [1:0] sel;
	int err_total = 0, samples_checked = 0;
	pou_byte_type nda, ndb, ena, enb, ts, pa, pb, da, db;
	localparam logic [15:0] UNMAP = 16'h0020;
	localparam logic [15:0] IX [11] = '{`POU_IDX_NDB_G3, `POU_IDX_NDB_G2,
		`POU_IDX_NDA_G1, `POU_IDX_NDA_G0, `POU_IDX_EN_A, `POU_IDX_EN_B,
		`POU_IDX_PDA, `POU_IDX_PDB, `POU_IDX_DIR_A, `POU_IDX_DIR_B,
		`POU_IDX_TSEL};
	wire sa = ts[3:2] != ts[1:0];
	wire sb = ts[7:6] != ts[5:4];
	pou_top uut (.*);
	pou_timer_model tm (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
		.req_in(req), .cm_a_out(cm_a_in));
	always #25 sys_clk_in = ~sys_clk_in;
	task mreset;
		{nda, ndb, ena, enb, pa, pb, da, db} = '0;
		ts = 8'hFF;
	endtask : mreset
	function automatic logic [31:0] rd(input logic [15:0] ix);
		case (ix)
		`POU_IDX_NDB_G3: rd = sb ? {ndb[7:4], 4'hF} : ndb;
		`POU_IDX_NDB_G2: rd = sb ? {4'hF, ndb[3:0]} : 8'hFF;
		`POU_IDX_NDA_G1: rd = sa ? {nda[7:4], 4'hF} : nda;
		`POU_IDX_NDA_G0: rd = sa ? {4'hF, nda[3:0]} : 8'hFF;
		`POU_IDX_EN_A: rd = ena;
		`POU_IDX_EN_B: rd = enb;
		`POU_IDX_TSEL: rd = ts;
		`POU_IDX_PDA: rd = pa;
		`POU_IDX_PDB: rd = pb;
		`POU_IDX_DIR_A: rd = da;
		`POU_IDX_DIR_B: rd = db;
		default: rd = 32'h0;
		endcase
	endfunction : rd
	task mw(input logic [15:0] ix, input pou_byte_type d);
		case (ix)
		`POU_IDX_NDB_G3: ndb = sb ? {d[7:4], ndb[3:0]} : d;
		`POU_IDX_NDB_G2: ndb = sb ? {ndb[7:4], d[3:0]} : ndb;
		`POU_IDX_NDA_G1: nda = sa ? {d[7:4], nda[3:0]} : d;
		`POU_IDX_NDA_G0: nda = sa ? {nda[7:4], d[3:0]} : nda;
		`POU_IDX_EN_A: ena = d;
		`POU_IDX_EN_B: enb = d;
		`POU_IDX_TSEL: ts = d;
		`POU_IDX_PDA: pa = pa & ena | d & ~ena;
		`POU_IDX_PDB: pb = pb & enb | d & ~enb;
		`POU_IDX_DIR_A: da = d;
		`POU_IDX_DIR_B: db = d;
		default: ;
		endcase
	endtask : mw
	task apb(input logic [15:0] ix, input logic w, input pou_byte_type d,
		input logic [3:0] s);
		@(posedge sys_clk_in);
		psel_in <= 1'h1;
		pwrite_in <= w;
		paddr_in <= {2'h0, ix, 2'h0};
		pwdata_in <= {24'h0, d};
		pstrb_in <= s;
		@(posedge sys_clk_in);
		penable_in <= 1'h1;
		@(posedge sys_clk_in);
		while (pready_out !== 1'h1) @(posedge sys_clk_in);
		r = prdata_out;
		`CHK(pslverr_out, ix == UNMAP);
		if (!w) `CHK(r, rd(ix));
		if (w && s[0]) mw(ix, d);
		psel_in <= 1'h0;
		penable_in <= 1'h0;
	endtask : apb
	task trig(input logic [3:0] c);
		pou_byte_type mk;
		@(posedge sys_clk_in);
		req <= c;
		@(posedge sys_clk_in);
		req <= 4'h0;
		for (int g = 0; g < 4; g++) begin
			mk = c[ts[2*g+:2]] ? 8'hF << 4 * (g % 2) : 8'h0;
			if (g < 2) pa = pa & ~(mk & ena) | nda & mk & ena;
			else pb = pb & ~(mk & enb) | ndb & mk & enb;
		end
		repeat (2) @(posedge sys_clk_in);
		#1;
		`CHK(port_a_out, pa);
		`CHK(port_b_out, pb);
		`CHK(port_b_oe_out, db);
		`CHK(port_a_oe_out, da);
	endtask : trig
	task finish_test;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test
	initial begin
		#1_000_000;
		err_total++;
		finish_test();
	end
	initial begin
		mreset();
		void'($urandom(95831));
		repeat (12) @(posedge sys_clk_in);
		rst_n_in <= 1'h1;
		foreach (IX[i]) apb(IX[i], 1'h0, 8'h00, 4'h0);
		apb(UNMAP, 1'h1, 8'h5A, 4'hF);
		apb(UNMAP, 1'h0, 8'h00, 4'h0);
		// every select code per group, split layout
		for (int k = 0; k < 16; k++) begin
			sel = k[3:2];
			apb(`POU_IDX_TSEL, 1'h1,
				{sel, sel ^ 2'h1, sel ^ 2'h2, sel ^ 2'h3}, 4'hF);
			for (int j = 0; j < 10; j++) apb(IX[j], 1'h1, $urandom, 4'hF);
			trig(4'h1 << k[1:0]);
			foreach (IX[i]) apb(IX[i], 1'h0, 8'h00, 4'h0);
		end
		repeat (40) begin
			apb(IX[$urandom % 11], $urandom, $urandom, $urandom);
			trig($urandom);
		end
		@(posedge sys_clk_in);
		hw_standby_in <= 1'h1;
		@(posedge sys_clk_in);
		hw_standby_in <= 1'h0;
		mreset();
		foreach (IX[i]) apb(IX[i], 1'h0, 8'h00, 4'h0);
		trig(4'hF);
		// shared trigger layout: full byte at first address, second ignored
		for (int j = 0; j < 10; j++) apb(IX[j], 1'h1, $urandom, 4'hF);
		trig(4'h8);
		foreach (IX[i]) apb(IX[i], 1'h0, 8'h00, 4'h0);
		finish_test();
	end
endmodule : pou_top_bench

//--- verilog/pou_pkg.sv
// types of the pattern output unit
package pou_pkg;
	typedef logic [7:0] pou_byte_type;
	typedef logic [3:0] pou_nib_type;
	typedef enum logic {
		POU_LAYOUT_SAME,
		POU_LAYOUT_SPLIT
	} pou_layout_type;
endpackage : pou_pkg

//--- verilog/pou_port_xfer.sv
// one 8-bit port data register with per-bit next data transfer
`timescale 1ns/1ps
`include "pou_regs.svh"
module pou_port_xfer import pou_pkg::*; #(
	parameter int WIDTH = 8,
	parameter int GRP_LO = 0
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic hw_standby_in,
	input wire logic [WIDTH-1:0] next_in,
	input wire logic [WIDTH-1:0] enable_in,
	input wire logic sw_wr_in,
	input wire logic [WIDTH-1:0] sw_data_in,
	pou_trig_if.dst trig_if,
	output logic [WIDTH-1:0] data_out
);
	logic [WIDTH-1:0] data_ff;
	logic [WIDTH-1:0] nxt_data;
	for (genvar b = 0; b < WIDTH; b++) begin : g_bit
		wire logic trig = trig_if.grp_trig[GRP_LO + b / `POU_NIB_W];
		wire logic take = trig & enable_in[b];
		// enabled bits ignore software writes
		wire logic sw_take = sw_wr_in & ~enable_in[b];
		assign nxt_data[b] = take ? next_in[b] :
			sw_take ? sw_data_in[b] : data_ff[b];
	end
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			data_ff <= WIDTH'(`POU_RST_PD);
		end else if (hw_standby_in) begin
			data_ff <= WIDTH'(`POU_RST_PD);
		end else begin
			data_ff <= nxt_data;
		end
	end
	assign data_out = data_ff;
endmodule : pou_port_xfer

//--- verilog/pou_regs.svh
// register indices, field widths, reset values of the pattern output unit
`ifndef POU_REGS_SVH
`define POU_REGS_SVH
`define POU_IDX_NDB_G3 16'hFFA4
`define POU_IDX_NDA_G1 16'hFFA5
`define POU_IDX_NDB_G2 16'hFFA6
`define POU_IDX_NDA_G0 16'hFFA7
`define POU_IDX_EN_A 16'h0010
`define POU_IDX_EN_B 16'h0011
`define POU_IDX_TSEL 16'h0012
`define POU_IDX_PDA 16'h0013
`define POU_IDX_PDB 16'h0014
`define POU_IDX_DIR_A 16'h0015
`define POU_IDX_DIR_B 16'h0016
`define POU_RST_ND 8'h00
`define POU_RST_EN 8'h00
`define POU_RST_TSEL 8'hFF
`define POU_RST_PD 8'h00
`define POU_RST_DIR 8'h00
`define POU_RSVD_NIB 4'hF
`define POU_RSVD_BYTE 8'hFF
`define POU_SEL_W 2
`define POU_NIB_W 4
`endif

//--- verilog/pou_top.sv
// pattern output unit: APB registers, trigger select, port data outputs
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "pou_regs.svh"
module pou_top import pou_pkg::*; #(
	parameter int ADDR_W = 20
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic hw_standby_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic [3:0] cm_a_in,
	output logic [7:0] port_a_out,
	output logic [7:0] port_a_oe_out,
	output logic [7:0] port_b_out,
	output logic [7:0] port_b_oe_out
);
	localparam int IDX_W = ADDR_W - 2;

	pou_byte_type nda_ff, ndb_ff, en_a_ff, en_b_ff, tsel_ff;
	pou_byte_type dir_a_ff, dir_b_ff;
	pou_byte_type rdata_ff;
	logic slverr_ff;
	pou_byte_type pda, pdb;
	pou_layout_type layout_a, layout_b;

	// address decode
	wire logic [IDX_W-1:0] idx = paddr_in[ADDR_W-1:2];
	wire logic hit_b3 = idx == IDX_W'(`POU_IDX_NDB_G3);
	wire logic hit_a1 = idx == IDX_W'(`POU_IDX_NDA_G1);
	wire logic hit_b2 = idx == IDX_W'(`POU_IDX_NDB_G2);
	wire logic hit_a0 = idx == IDX_W'(`POU_IDX_NDA_G0);
	wire logic hit_ena = idx == IDX_W'(`POU_IDX_EN_A);
	wire logic hit_enb = idx == IDX_W'(`POU_IDX_EN_B);
	wire logic hit_tsel = idx == IDX_W'(`POU_IDX_TSEL);
	wire logic hit_pda = idx == IDX_W'(`POU_IDX_PDA);
	wire logic hit_pdb = idx == IDX_W'(`POU_IDX_PDB);
	wire logic hit_dira = idx == IDX_W'(`POU_IDX_DIR_A);
	wire logic hit_dirb = idx == IDX_W'(`POU_IDX_DIR_B);
	wire logic mapped = hit_b3 | hit_a1 | hit_b2 | hit_a0 | hit_ena |
		hit_enb | hit_tsel | hit_pda | hit_pdb | hit_dira | hit_dirb;

	// access phase write, low byte lane only
	wire logic setup = psel_in & ~penable_in;
	wire logic wr = psel_in & penable_in & pwrite_in & pstrb_in[0];
	wire pou_byte_type wd = pwdata_in[7:0];

	// layout follows whether the two groups of a half share a trigger
	assign layout_b = (tsel_ff[7:6] != tsel_ff[5:4]) ?
		POU_LAYOUT_SPLIT : POU_LAYOUT_SAME;
	assign layout_a = (tsel_ff[3:2] != tsel_ff[1:0]) ?
		POU_LAYOUT_SPLIT : POU_LAYOUT_SAME;
	wire logic split_b = layout_b == POU_LAYOUT_SPLIT;
	wire logic split_a = layout_a == POU_LAYOUT_SPLIT;

	// next data: high nibble at first address, low nibble at second if split
	wire pou_nib_type nxt_ndb_hi = (wr & hit_b3) ? wd[7:4] : ndb_ff[7:4];
	wire pou_nib_type nxt_ndb_lo =
		(wr & hit_b3 & ~split_b) ? wd[3:0] :
		(wr & hit_b2 & split_b) ? wd[3:0] : ndb_ff[3:0];
	wire pou_nib_type nxt_nda_hi = (wr & hit_a1) ? wd[7:4] : nda_ff[7:4];
	wire pou_nib_type nxt_nda_lo =
		(wr & hit_a1 & ~split_a) ? wd[3:0] :
		(wr & hit_a0 & split_a) ? wd[3:0] : nda_ff[3:0];
	wire pou_byte_type nxt_ndb = {nxt_ndb_hi, nxt_ndb_lo};
	wire pou_byte_type nxt_nda = {nxt_nda_hi, nxt_nda_lo};

	// read views of the next data addresses
	wire pou_byte_type rd_b3 = split_b ?
		{ndb_ff[7:4], `POU_RSVD_NIB} : ndb_ff;
	wire pou_byte_type rd_b2 = split_b ?
		{`POU_RSVD_NIB, ndb_ff[3:0]} : `POU_RSVD_BYTE;
	wire pou_byte_type rd_a1 = split_a ?
		{nda_ff[7:4], `POU_RSVD_NIB} : nda_ff;
	wire pou_byte_type rd_a0 = split_a ?
		{`POU_RSVD_NIB, nda_ff[3:0]} : `POU_RSVD_BYTE;
	wire pou_byte_type nxt_rdata =
		hit_b3 ? rd_b3 :
		hit_b2 ? rd_b2 :
		hit_a1 ? rd_a1 :
		hit_a0 ? rd_a0 :
		hit_ena ? en_a_ff :
		hit_enb ? en_b_ff :
		hit_tsel ? tsel_ff :
		hit_pda ? pda :
		hit_pdb ? pdb :
		hit_dira ? dir_a_ff :
		hit_dirb ? dir_b_ff : 8'h00;

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			nda_ff <= `POU_RST_ND;
			ndb_ff <= `POU_RST_ND;
		end else if (hw_standby_in) begin
			nda_ff <= `POU_RST_ND;
			ndb_ff <= `POU_RST_ND;
		end else begin
			nda_ff <= nxt_nda;
			ndb_ff <= nxt_ndb;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			en_a_ff <= `POU_RST_EN;
			en_b_ff <= `POU_RST_EN;
			tsel_ff <= `POU_RST_TSEL;
		end else if (hw_standby_in) begin
			en_a_ff <= `POU_RST_EN;
			en_b_ff <= `POU_RST_EN;
			tsel_ff <= `POU_RST_TSEL;
		end else begin
			en_a_ff <= (wr & hit_ena) ? wd : en_a_ff;
			en_b_ff <= (wr & hit_enb) ? wd : en_b_ff;
			tsel_ff <= (wr & hit_tsel) ? wd : tsel_ff;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dir_a_ff <= `POU_RST_DIR;
			dir_b_ff <= `POU_RST_DIR;
		end else if (hw_standby_in) begin
			dir_a_ff <= `POU_RST_DIR;
			dir_b_ff <= `POU_RST_DIR;
		end else begin
			dir_a_ff <= (wr & hit_dira) ? wd : dir_a_ff;
			dir_b_ff <= (wr & hit_dirb) ? wd : dir_b_ff;
		end
	end

	// read data captured in setup, presented during access
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_ff <= 8'h00;
			slverr_ff <= 1'b0;
		end else if (setup) begin
			rdata_ff <= pwrite_in ? 8'h00 : nxt_rdata;
			slverr_ff <= ~mapped;
		end
	end

	pou_trig_if trig_if ();

	pou_trig_sel #(.GROUPS(4), .CHANNELS(4)) u_trig_sel (
		.sel_in(tsel_ff),
		.cm_a_in(cm_a_in),
		.trig_if(trig_if.src)
	);

	pou_port_xfer #(.WIDTH(8), .GRP_LO(0)) u_port_a (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.hw_standby_in(hw_standby_in),
		.next_in(nda_ff),
		.enable_in(en_a_ff),
		.sw_wr_in(wr & hit_pda),
		.sw_data_in(wd),
		.trig_if(trig_if.dst),
		.data_out(pda)
	);

	pou_port_xfer #(.WIDTH(8), .GRP_LO(2)) u_port_b (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.hw_standby_in(hw_standby_in),
		.next_in(ndb_ff),
		.enable_in(en_b_ff),
		.sw_wr_in(wr & hit_pdb),
		.sw_data_in(wd),
		.trig_if(trig_if.dst),
		.data_out(pdb)
	);

	// pin drives the port data whenever its direction bit is set
	assign port_a_out = pda;
	assign port_b_out = pdb;
	assign port_a_oe_out = dir_a_ff;
	assign port_b_oe_out = dir_b_ff;

	assign pready_out = psel_in & penable_in;
	assign pslverr_out = psel_in & penable_in & slverr_ff;
	assign prdata_out = {24'h000000, rdata_ff};
endmodule : pou_top

//--- verilog/pou_trig_if.sv
// group trigger pulses between selector and port transfer logic
`timescale 1ns/1ps
interface pou_trig_if;
	logic [3:0] grp_trig;
	modport src (output grp_trig);
	modport dst (input grp_trig);
endinterface : pou_trig_if

//--- verilog/pou_trig_sel.sv
// per-group compare match trigger selection
`timescale 1ns/1ps
`include "pou_regs.svh"
module pou_trig_sel import pou_pkg::*; #(
	parameter int GROUPS = 4,
	parameter int CHANNELS = 4
) (
	input wire logic [2*GROUPS-1:0] sel_in,
	input wire logic [CHANNELS-1:0] cm_a_in,
	pou_trig_if.src trig_if
);
	// group g follows channel sel[2g+1:2g]
	for (genvar g = 0; g < GROUPS; g++) begin : g_grp
		wire logic [`POU_SEL_W-1:0] ch_sel = sel_in[2*g +: `POU_SEL_W];
		assign trig_if.grp_trig[g] = cm_a_in[ch_sel];
	end
endmodule : pou_trig_sel
